//--- bench/dlc_top_sva.sv
// Port checker for the level code double buffer top.
// Bound to dlc_top; sees only its register port and code outputs.
`timescale 1ns/10ps
`default_nettype none
`include "dlc_map.vh"
module dlc_top_sva (
    input wire logic REF_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [7:0] RDATA_OUT,
    input wire logic [9:0] LEVEL_CODE_ONE_OUT,
    input wire logic [9:0] LEVEL_CODE_TWO_OUT
);
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RST_B_IN);
    // Shadow of format bit of converter one, so byte views can be judged
    logic fmt_ff;
    always @(posedge REF_CLK_IN) begin
        if (!RST_B_IN)
            fmt_ff <= 1'b0;
        else if (WR_IN && ADDR_IN == 4'h0)
            fmt_ff <= WDATA_IN[6];
    end
    sequence ld_s;
        WR_IN && ADDR_IN == 4'h6 && WDATA_IN[0];
    endsequence
    sequence ld_rd_s;
        RD_IN && ADDR_IN == 4'h6;
    endsequence
    ////////////////////////////////////////
    load_set_a: assert property (ld_s ##1 ld_rd_s |=> RDATA_OUT[0])
        else $error("load bit not set after write");
    load_clear_a: assert property (ld_s ##1 !WR_IN ##1 ld_rd_s |=> !RDATA_OUT[0])
        else $error("load bit not cleared");
    hold_one_a: assert property ($changed(LEVEL_CODE_ONE_OUT) |-> $past(WR_IN && ADDR_IN == 4'h6 && WDATA_IN[0], 2))
        else $error("code one moved without load");
    hold_two_a: assert property ($changed(LEVEL_CODE_TWO_OUT) |-> $past(WR_IN && ADDR_IN == 4'h6 && WDATA_IN[1], 2))
        else $error("code two moved without load");
    load_rsvd_a: assert property (ld_rd_s |=> RDATA_OUT[7:2] == 6'h00)
        else $error("load spare bits not zero");
    high_right_a: assert property (RD_IN && ADDR_IN == 4'h1 && !fmt_ff |=> RDATA_OUT[7:2] == 6'h00)
        else $error("right high byte upper bits not zero");
    low_left_a: assert property (RD_IN && ADDR_IN == 4'h2 && fmt_ff |=> RDATA_OUT[5:0] == 6'h00)
        else $error("left low byte lower bits not zero");
    rdata_idle_a: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
        else $error("read data outside read answer");
endmodule
bind dlc_top dlc_top_sva u_sva (.REF_CLK_IN(REF_CLK_IN), .RST_B_IN(RST_B_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
    .LEVEL_CODE_ONE_OUT(LEVEL_CODE_ONE_OUT), .LEVEL_CODE_TWO_OUT(LEVEL_CODE_TWO_OUT));
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the level code double buffer.
// Drives the register port directly; expectations from a byte-view model.
`timescale 1ns/10ps
`default_nettype none
`include "dlc_map.vh"
module tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    wire [7:0] rdata;
    wire [9:0] code_one;
    wire [9:0] code_two;
    wire en_one, oe_one, neg_one, en_two, oe_two, neg_two;
    wire [1:0] pos_one, pos_two;
    wire [4:0] pins_one = {en_one, oe_one, pos_one, neg_one};
    wire [4:0] pins_two = {en_two, oe_two, pos_two, neg_two};
    int fails = 0;
    int n_tests = 0;
    logic [9:0] stg [2];
    logic [9:0] act [2];
    logic fmt [2];
    logic [7:0] d;
    int c;
    dlc_top u_dut (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
        .RDATA_OUT(rdata), .LEVEL_CODE_ONE_OUT(code_one), .CONV_ONE_EN_OUT(en_one), .CONV_ONE_PIN_OE_OUT(oe_one),
        .CONV_ONE_POS_SRC_OUT(pos_one), .CONV_ONE_NEG_SRC_OUT(neg_one), .LEVEL_CODE_TWO_OUT(code_two),
        .CONV_TWO_EN_OUT(en_two), .CONV_TWO_PIN_OE_OUT(oe_two), .CONV_TWO_POS_SRC_OUT(pos_two),
        .CONV_TWO_NEG_SRC_OUT(neg_two));
    initial forever #2.5 clk = ~clk;
    ////////////////////////////////////////
    function automatic logic [7:0] view(logic [9:0] s, logic f, logic hi);
        if (hi)
            return f ? s[9:2] : {6'h00, s[9:8]};
        return f ? {s[1:0], 6'h00} : s[7:0];
    endfunction
    task automatic chk(string name, logic [9:0] seen, logic [9:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr_reg(logic [3:0] a, logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(logic [3:0] a, logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", {2'b00, rdata}, {2'b00, e});
    endtask
    // Staged write; model follows the format bit current at write time
    task automatic put(int k, logic [7:0] v);
        wr_reg(4'(c * 3 + k), v);
        if (k == 0)
            fmt[c] = v[6];
        else if (k == 1)
            stg[c] = fmt[c] ? {v, stg[c][1:0]} : {v[1:0], stg[c][7:0]};
        else
            stg[c] = fmt[c] ? {stg[c][9:2], v[7:6]} : {stg[c][9:8], v};
    endtask
    // Load, then two back-to-back reads: strobe standing, then cleared
    task automatic load(logic [7:0] v);
        wr_reg(4'h6, v);
        rd <= 1'b1;
        addr <= 4'h6;
        @(posedge clk);
        #1;
        chk("load_bits", {2'b00, rdata}, {8'h00, v[1:0]});
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("load_clr", {2'b00, rdata}, 10'h000);
        for (int i = 0; i < 2; i++)
            if (v[i])
                act[i] = stg[i];
        chk("code_one", code_one, act[0]);
        chk("code_two", code_two, act[1]);
    endtask
    task automatic check_all();
        for (c = 0; c < 2; c++) begin
            rd_reg(4'(c * 3 + 1), view(stg[c], fmt[c], 1'b1));
            rd_reg(4'(c * 3 + 2), view(stg[c], fmt[c], 1'b0));
            rd_reg(4'(7 + c * 2), view(act[c], fmt[c], 1'b1));
            rd_reg(4'(8 + c * 2), view(act[c], fmt[c], 1'b0));
        end
        chk("code_one", code_one, act[0]);
        chk("code_two", code_two, act[1]);
    endtask
    task automatic do_reset();
        if (rst_b)
            @(posedge clk);
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            stg[i] = 10'h000;
            act[i] = 10'h000;
            fmt[i] = 1'b0;
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h1feedf0c));
        do_reset();
        check_all();
        for (int i = 0; i < 80; i++) begin
            c = $urandom_range(1);
            d = (i < 4) ? 8'hff : 8'($urandom());
            put(0, d);
            rd_reg(4'(c * 3), d & 8'hed);
            chk("ctrl_pins", {5'h00, c ? pins_two : pins_one}, {5'h00, d[7], d[5], d[3:2], d[0]});
            put(1, (i < 4) ? 8'hff : 8'($urandom()));
            put(2, (i < 4) ? 8'hff : 8'($urandom()));
            // Read-only and unmapped places must swallow writes
            wr_reg(4'(7 + c), 8'h5a);
            wr_reg(4'hc, 8'hff);
            rd_reg(4'hc, 8'h00);
            check_all();
            if (i < 4 || $urandom_range(1))
                load((i < 4) ? 8'hff : 8'($urandom()));
            if (i == 40) begin
                do_reset();
                check_all();
            end
        end
        print_verdict();
    end
    // Run should end near 2600 cycles; a hang stops here
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        print_verdict();
    end
endmodule
`default_nettype wire

//--- verilog/dlc_conv_slot.v
// One converter: control byte, staged code and active code buffer.
// Assumes one-cycle write strobes from the register decoder on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "dlc_map.vh"

module dlc_conv_slot (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Register writes
    input wire wr_ctrl,
    input wire wr_high,
    input wire wr_low,
    input wire [7:0] wdata,
    // Load request, one cycle
    input wire load,
    // Readback and outputs
    output wire [7:0] ctrl,
    output reg [7:0] high_rd,
    output reg [7:0] low_rd,
    output reg [7:0] act_high_rd,
    output reg [7:0] act_low_rd,
    output wire [`DLC_CODE_W-1:0] active
);

reg [7:0] ctrl_ff;
reg [`DLC_CODE_W-1:0] staged_ff;
reg [`DLC_CODE_W-1:0] active_ff;
reg [`DLC_CODE_W-1:0] nxt_staged;
wire left_just;

assign left_just = ctrl_ff[`DLC_CTRL_JUSTIFY_BIT];
assign ctrl = ctrl_ff;
assign active = active_ff;

////////////////////////////////////////////////////////////////////////////////
// Staged code: one 10-bit store, bytes mapped by the current format
always @* begin
    nxt_staged = staged_ff;
    if (wr_high) begin
        if (left_just) begin
            nxt_staged[9:2] = wdata;
        end else begin
            nxt_staged[9:8] = wdata[1:0];
        end
    end
    if (wr_low) begin
        if (left_just) begin
            nxt_staged[1:0] = wdata[7:6];
        end else begin
            nxt_staged[7:0] = wdata;
        end
    end
end

// Format change keeps the stored code; only the byte view moves
always @* begin
    if (left_just) begin
        high_rd = staged_ff[9:2];
        low_rd = {staged_ff[1:0], 6'h00};
        act_high_rd = active_ff[9:2];
        act_low_rd = {active_ff[1:0], 6'h00};
    end else begin
        high_rd = {6'h00, staged_ff[9:8]};
        low_rd = staged_ff[7:0];
        act_high_rd = {6'h00, active_ff[9:8]};
        act_low_rd = active_ff[7:0];
    end
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge clk) begin
    if (!rst_b) begin
        ctrl_ff <= `DLC_RST_BYTE;
        staged_ff <= `DLC_RST_CODE;
        active_ff <= `DLC_RST_CODE;
    end else begin
        if (wr_ctrl) begin
            ctrl_ff <= wdata & `DLC_CTRL_WMASK;
        end
        staged_ff <= nxt_staged;
        // All ten bits move in one edge, only on a load
        if (load) begin
            active_ff <= staged_ff;
        end
    end
end

endmodule
`default_nettype wire

//--- verilog/dlc_map.vh
// Register map and field constants for the level code double buffer.
// Assumes an 8-bit register port with a 4-bit word address.
`ifndef DLC_MAP_VH
`define DLC_MAP_VH

// Register addresses
`define DLC_ADDR_W 4
`define DLC_OFS_CTRL_ONE 4'h0
`define DLC_OFS_HIGH_ONE 4'h1
`define DLC_OFS_LOW_ONE 4'h2
`define DLC_OFS_CTRL_TWO 4'h3
`define DLC_OFS_HIGH_TWO 4'h4
`define DLC_OFS_LOW_TWO 4'h5
`define DLC_OFS_LOAD 4'h6
`define DLC_OFS_ACT_HIGH_ONE 4'h7
`define DLC_OFS_ACT_LOW_ONE 4'h8
`define DLC_OFS_ACT_HIGH_TWO 4'h9
`define DLC_OFS_ACT_LOW_TWO 4'ha

// Converter control register fields
`define DLC_CTRL_EN_BIT 7
`define DLC_CTRL_JUSTIFY_BIT 6
`define DLC_CTRL_OE_BIT 5
`define DLC_CTRL_PSS_HI 3
`define DLC_CTRL_PSS_LO 2
`define DLC_CTRL_NSS_BIT 0
`define DLC_CTRL_WMASK 8'hed

// Load register fields
`define DLC_LOAD_ONE_BIT 0
`define DLC_LOAD_TWO_BIT 1
`define DLC_LOAD_WMASK 8'h03

// Widths and reset values
`define DLC_CODE_W 10
`define DLC_RST_BYTE 8'h00
`define DLC_RST_CODE 10'h000

`endif

//--- verilog/dlc_top.v
// Top of the level code double buffer for two converters.
// Assumes a single-master register port on REF_CLK_IN; read data one cycle late.
// Two converter slots share one register port and one load register.
`timescale 1ns/10ps
`default_nettype none
`include "dlc_map.vh"

module dlc_top (
    // Clock and reset
    input wire REF_CLK_IN,
    input wire RST_B_IN,
    // Register port
    input wire [`DLC_ADDR_W-1:0] ADDR_IN,
    input wire [7:0] WDATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    output wire [7:0] RDATA_OUT,
    // Converter one
    output wire [`DLC_CODE_W-1:0] LEVEL_CODE_ONE_OUT,
    output wire CONV_ONE_EN_OUT,
    output wire CONV_ONE_PIN_OE_OUT,
    output wire [1:0] CONV_ONE_POS_SRC_OUT,
    output wire CONV_ONE_NEG_SRC_OUT,
    // Converter two
    output wire [`DLC_CODE_W-1:0] LEVEL_CODE_TWO_OUT,
    output wire CONV_TWO_EN_OUT,
    output wire CONV_TWO_PIN_OE_OUT,
    output wire [1:0] CONV_TWO_POS_SRC_OUT,
    output wire CONV_TWO_NEG_SRC_OUT
);

////////////////////////////////////////////////////////////////////////////////
// Address decode
// Offsets 7 to a are read-only views of the active code; no write
// strobe is decoded for them, so writes there fall away quietly.
// Unmapped offsets behave the same way and read back as zero.

wire wr_ctrl_one;
wire wr_high_one;
wire wr_low_one;
wire wr_ctrl_two;
wire wr_high_two;
wire wr_low_two;
wire wr_load;

assign wr_ctrl_one = WR_IN && (ADDR_IN == `DLC_OFS_CTRL_ONE);
assign wr_high_one = WR_IN && (ADDR_IN == `DLC_OFS_HIGH_ONE);
assign wr_low_one = WR_IN && (ADDR_IN == `DLC_OFS_LOW_ONE);
assign wr_ctrl_two = WR_IN && (ADDR_IN == `DLC_OFS_CTRL_TWO);
assign wr_high_two = WR_IN && (ADDR_IN == `DLC_OFS_HIGH_TWO);
assign wr_low_two = WR_IN && (ADDR_IN == `DLC_OFS_LOW_TWO);
assign wr_load = WR_IN && (ADDR_IN == `DLC_OFS_LOAD);

////////////////////////////////////////////////////////////////////////////////
// Load strobes
// A strobe stands one cycle, then the copy happens and hardware clears it.
// A new write of one in that same cycle wins over the clear.

localparam [7:0] LOAD_WMASK = `DLC_LOAD_WMASK;

reg [1:0] load_ff;
reg [1:0] nxt_load;
wire [1:0] load_set;

// Spare bits are masked here so they can never arm a strobe
assign load_set = wr_load ? (WDATA_IN[1:0] & LOAD_WMASK[1:0]) : 2'h0;

always @* begin
    nxt_load = 2'h0;
    nxt_load[`DLC_LOAD_ONE_BIT] = load_set[`DLC_LOAD_ONE_BIT];
    nxt_load[`DLC_LOAD_TWO_BIT] = load_set[`DLC_LOAD_TWO_BIT];
end

always @(posedge REF_CLK_IN) begin
    if (!RST_B_IN) begin
        load_ff <= 2'h0;
    end else begin
        // Clear after one cycle; a fresh set re-arms it
        load_ff <= nxt_load;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Converter slots
// Each slot keeps its own format bit, so the two converters may
// use different justifications side by side.

wire [7:0] ctrl_one;
wire [7:0] high_one;
wire [7:0] low_one;
wire [7:0] act_high_one;
wire [7:0] act_low_one;
wire [7:0] ctrl_two;
wire [7:0] high_two;
wire [7:0] low_two;
wire [7:0] act_high_two;
wire [7:0] act_low_two;

dlc_conv_slot u_slot_one (
    .clk(REF_CLK_IN),
    .rst_b(RST_B_IN),
    .wr_ctrl(wr_ctrl_one),
    .wr_high(wr_high_one),
    .wr_low(wr_low_one),
    .wdata(WDATA_IN),
    .load(load_ff[`DLC_LOAD_ONE_BIT]),
    .ctrl(ctrl_one),
    .high_rd(high_one),
    .low_rd(low_one),
    .act_high_rd(act_high_one),
    .act_low_rd(act_low_one),
    .active(LEVEL_CODE_ONE_OUT)
);

dlc_conv_slot u_slot_two (
    .clk(REF_CLK_IN),
    .rst_b(RST_B_IN),
    .wr_ctrl(wr_ctrl_two),
    .wr_high(wr_high_two),
    .wr_low(wr_low_two),
    .wdata(WDATA_IN),
    .load(load_ff[`DLC_LOAD_TWO_BIT]),
    .ctrl(ctrl_two),
    .high_rd(high_two),
    .low_rd(low_two),
    .act_high_rd(act_high_two),
    .act_low_rd(act_low_two),
    .active(LEVEL_CODE_TWO_OUT)
);

////////////////////////////////////////////////////////////////////////////////
// Control fields toward the analog side
// These follow the control byte at once; the analog side must
// tolerate a change of source while the ladder is live.

assign CONV_ONE_EN_OUT = ctrl_one[`DLC_CTRL_EN_BIT];
assign CONV_ONE_PIN_OE_OUT = ctrl_one[`DLC_CTRL_OE_BIT];
assign CONV_ONE_POS_SRC_OUT = ctrl_one[`DLC_CTRL_PSS_HI:`DLC_CTRL_PSS_LO];
assign CONV_ONE_NEG_SRC_OUT = ctrl_one[`DLC_CTRL_NSS_BIT];
assign CONV_TWO_EN_OUT = ctrl_two[`DLC_CTRL_EN_BIT];
assign CONV_TWO_PIN_OE_OUT = ctrl_two[`DLC_CTRL_OE_BIT];
assign CONV_TWO_POS_SRC_OUT = ctrl_two[`DLC_CTRL_PSS_HI:`DLC_CTRL_PSS_LO];
assign CONV_TWO_NEG_SRC_OUT = ctrl_two[`DLC_CTRL_NSS_BIT];

////////////////////////////////////////////////////////////////////////////////
// Read path
// Data is registered and shows only in the cycle after the strobe,
// zero otherwise, so a stale value is never mistaken for an answer.
// Active views read through the current format, like the staged bytes.

reg [7:0] rdata_ff;
reg [7:0] nxt_rdata;

always @* begin
    nxt_rdata = 8'h00;
    if (RD_IN) begin
        case (ADDR_IN)
            `DLC_OFS_CTRL_ONE: begin
                nxt_rdata = ctrl_one;
            end
            `DLC_OFS_HIGH_ONE: begin
                nxt_rdata = high_one;
            end
            `DLC_OFS_LOW_ONE: begin
                nxt_rdata = low_one;
            end
            `DLC_OFS_CTRL_TWO: begin
                nxt_rdata = ctrl_two;
            end
            `DLC_OFS_HIGH_TWO: begin
                nxt_rdata = high_two;
            end
            `DLC_OFS_LOW_TWO: begin
                nxt_rdata = low_two;
            end
            `DLC_OFS_LOAD: begin
                nxt_rdata = {6'h00, load_ff};
            end
            `DLC_OFS_ACT_HIGH_ONE: begin
                nxt_rdata = act_high_one;
            end
            `DLC_OFS_ACT_LOW_ONE: begin
                nxt_rdata = act_low_one;
            end
            `DLC_OFS_ACT_HIGH_TWO: begin
                nxt_rdata = act_high_two;
            end
            `DLC_OFS_ACT_LOW_TWO: begin
                nxt_rdata = act_low_two;
            end
            default: begin
                nxt_rdata = 8'h00;
            end
        endcase
    end
end

always @(posedge REF_CLK_IN) begin
    if (!RST_B_IN) begin
        rdata_ff <= 8'h00;
    end else begin
        rdata_ff <= nxt_rdata;
    end
end

assign RDATA_OUT = rdata_ff;

endmodule
`default_nettype wire
